// ==== include/pes_pkg.sv ====
// Contract
// [RL1] With real-time reporting on, current results are refreshed from live counts every update period.
// [RL2] With real-time reporting off, results only update on a clear or when the host disables a checker.
// [RL3] Each lane keeps a total bit counter beside its error counter.
// [RL4] Writing 1 to stats_clear_ctl zeroes the statistics and restarts accumulation on enabled lanes.
// [RL5] A gating-time field of zero selects non-gated operation.
// [RL6] In non-gated operation gate_auto_restart is ignored.
// [RL7] In global start/stop mode a clear acts on all lanes of all banks.
// [RL8] Just before a clear the live counts are copied to current and previous results.
// [RL9] After a clear current results start fresh while previous results keep the ended period.
// [RL10] While stats_clear_ctl is held at 1 the counters of enabled checkers are frozen and readable.
// [RL11] When stats_clear_ctl returns to 0 enabled host and media counters are zeroed and restarted.
// [RL12] Freeze and restart apply when lane_gate_timer_cap reads 0.
// [RL13] Disabling an enabled checker stops its counting and copies counts to both result sets.
// [RL14] The host reads frozen statistics before releasing stats_clear_ctl.
package pes_pkg;
    localparam int NUM_LANES = 8;
    localparam int ERR_W = 32;
    localparam int BIT_W = 48;
    localparam int BIT_STEP = 32;
    localparam int GATE_W = 3;
    localparam logic [GATE_W-1:0] GATE_NONE = 3'h0;
    localparam int UPD_W = 8;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int UPD_UNIT_MS = 1;
    localparam int UPD_UNIT_CYC = UPD_UNIT_MS * (SYS_CLK_HZ / 1000);

    typedef enum logic {
        PES_RUN,
        PES_FREEZE
    } pes_clr_state_t;
endpackage

// ==== include/pes_lane_if.sv ====
`timescale 1ns/1ps
interface pes_lane_if #(
    parameter int L = 16,
    parameter int EW = 32,
    parameter int BW = 48
);
    logic [L-1:0] run;
    logic [L-1:0] frz;
    logic [L-1:0] err_hit;
    logic [L-1:0] snap_cur;
    logic [L-1:0] snap_prev;
    logic [L-1:0] zap;
    logic [EW-1:0] cur_err [L];
    logic [EW-1:0] prev_err [L];
    logic [BW-1:0] cur_bit [L];
    logic [BW-1:0] prev_bit [L];

    modport ctl (output run, frz, err_hit, snap_cur, snap_prev, zap,
                 input cur_err, prev_err, cur_bit, prev_bit);
    modport lane (input run, frz, err_hit, snap_cur, snap_prev, zap,
                  output cur_err, prev_err, cur_bit, prev_bit);
endinterface

// ==== rtl/pes_tick_gen.sv ====
`timescale 1ns/1ps
module pes_tick_gen #(
    parameter int UNIT_CYC = pes_pkg::UPD_UNIT_CYC,
    parameter int PW = pes_pkg::UPD_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [PW-1:0] period,
    output logic tick
);
    logic [31:0] unit_cnt, next_unit_cnt;
    logic [PW-1:0] per_cnt, next_per_cnt;
    logic next_tick;

    // =====================================
    // divider: unit pulses, then period units
    always_comb begin
        next_unit_cnt = unit_cnt;
        next_per_cnt = per_cnt;
        next_tick = 1'b0;
        if (!en || period == '0) begin
            next_unit_cnt = '0;
            next_per_cnt = '0;
        end else if (unit_cnt == 32'(UNIT_CYC - 1)) begin
            next_unit_cnt = '0;
            if (per_cnt >= period - PW'(1)) begin
                next_per_cnt = '0;
                next_tick = 1'b1;
            end else begin
                next_per_cnt = per_cnt + PW'(1);
            end
        end else begin
            next_unit_cnt = unit_cnt + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            unit_cnt <= '0;
            per_cnt <= '0;
            tick <= 1'b0;
        end else begin
            unit_cnt <= next_unit_cnt;
            per_cnt <= next_per_cnt;
            tick <= next_tick;
        end
    end
endmodule // pes_tick_gen

// ==== rtl/pes_lane_stats.sv ====
`timescale 1ns/1ps
module pes_lane_stats #(
    parameter int IDX = 0,
    parameter int L = 16,
    parameter int EW = pes_pkg::ERR_W,
    parameter int BW = pes_pkg::BIT_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    pes_lane_if.lane lif
);
    logic [EW-1:0] live_err, next_live_err, next_cur_err, next_prev_err;
    logic [BW-1:0] live_bit, next_live_bit, next_cur_bit, next_prev_bit;
    logic counting;

    // =====================================
    // live counters and result copies
    always_comb begin
        counting = lif.run[IDX] && !lif.frz[IDX];
        next_live_err = live_err;
        next_live_bit = live_bit;
        if (lif.zap[IDX]) begin
            next_live_err = '0;
            next_live_bit = '0;
        end else if (counting) begin
            // saturate rather than wrap, a wrapped count would look like a clean link
            if (lif.err_hit[IDX] && live_err != '1)
                next_live_err = live_err + EW'(1);
            if (live_bit <= '1 - BW'(pes_pkg::BIT_STEP))
                next_live_bit = live_bit + BW'(pes_pkg::BIT_STEP); // RL3
        end
        next_cur_err = lif.cur_err[IDX];
        next_cur_bit = lif.cur_bit[IDX];
        if (lif.zap[IDX]) begin
            next_cur_err = '0; // RL9
            next_cur_bit = '0;
        end else if (lif.snap_cur[IDX]) begin
            next_cur_err = live_err;
            next_cur_bit = live_bit;
        end
        next_prev_err = lif.snap_prev[IDX] ? live_err : lif.prev_err[IDX]; // RL8
        next_prev_bit = lif.snap_prev[IDX] ? live_bit : lif.prev_bit[IDX];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            live_err <= '0;
            live_bit <= '0;
            lif.cur_err[IDX] <= '0;
            lif.cur_bit[IDX] <= '0;
            lif.prev_err[IDX] <= '0;
            lif.prev_bit[IDX] <= '0;
        end else begin
            live_err <= next_live_err;
            live_bit <= next_live_bit;
            lif.cur_err[IDX] <= next_cur_err;
            lif.cur_bit[IDX] <= next_cur_bit;
            lif.prev_err[IDX] <= next_prev_err;
            lif.prev_bit[IDX] <= next_prev_bit;
        end
    end

    // =====================================
    // checks
    a_frozen_count_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL10
        lif.frz[IDX] && !lif.zap[IDX] |=> live_err == $past(live_err) && live_bit == $past(live_bit))
        else $error("frozen lane counter moved");
    a_bit_count_step: assert property (@(posedge sys_clk) disable iff (rst) // RL3
        counting && !lif.zap[IDX] && live_bit < BW'(1000) |=> live_bit == $past(live_bit) + BW'(pes_pkg::BIT_STEP))
        else $error("bit counter did not advance");
    a_prev_kept_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL9
        lif.zap[IDX] && !lif.snap_prev[IDX] |=> lif.prev_err[IDX] == $past(lif.prev_err[IDX])
            && lif.cur_err[IDX] == '0 && live_err == '0)
        else $error("clear disturbed previous results");
endmodule // pes_lane_stats

// ==== rtl/pes_stats_ctl.sv ====
`timescale 1ns/1ps
module pes_stats_ctl #(
    parameter int N = pes_pkg::NUM_LANES,
    parameter int EW = pes_pkg::ERR_W,
    parameter int BW = pes_pkg::BIT_W,
    parameter int UPD_UNIT_CYC = pes_pkg::UPD_UNIT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [N-1:0] host_chk_en,
    input wire logic [N-1:0] media_chk_en,
    input wire logic [N-1:0] host_err_hit,
    input wire logic [N-1:0] media_err_hit,
    input wire logic rt_report_cap,
    input wire logic [pes_pkg::UPD_W-1:0] update_period,
    input wire logic stats_clear_ctl,
    input wire logic global_start_stop,
    input wire logic gate_auto_restart,
    input wire logic [pes_pkg::GATE_W-1:0] gate_time,
    input wire logic lane_gate_timer_cap,
    output logic frozen,
    output logic non_gated,
    output logic gate_restart_eff,
    output logic [EW-1:0] cur_err [2*N],
    output logic [EW-1:0] prev_err [2*N],
    output logic [BW-1:0] cur_bit [2*N],
    output logic [BW-1:0] prev_bit [2*N]
);
    localparam int L = 2 * N;

    pes_lane_if #(.L(L), .EW(EW), .BW(BW)) lif ();

    pes_pkg::pes_clr_state_t state, next_state;
    logic clr_q, next_clr_q;
    logic [L-1:0] chk_q, next_chk_q;
    logic [L-1:0] chk_en, scope, chk_fall;
    logic clr_rise, clr_fall, upd_tick;
    logic next_frozen, next_non_gated, next_gate_restart_eff;

    // lanes 0..N-1 face the host, N..2N-1 face the media
    assign chk_en = {media_chk_en, host_chk_en};
    assign lif.err_hit = {media_err_hit, host_err_hit};

    // =====================================
    // update-period divider
    pes_tick_gen #(.UNIT_CYC(UPD_UNIT_CYC), .PW(pes_pkg::UPD_W)) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .en(rt_report_cap), // RL2
        .period(update_period),
        .tick(upd_tick)
    );

    // =====================================
    // per-lane statistics
    for (genvar i = 0; i < L; i++) begin : g_lane
        pes_lane_stats #(.IDX(i), .L(L), .EW(EW), .BW(BW)) u_lane (
            .sys_clk(sys_clk),
            .rst(rst),
            .lif(lif)
        );
    end

    assign cur_err = lif.cur_err;
    assign prev_err = lif.prev_err;
    assign cur_bit = lif.cur_bit;
    assign prev_bit = lif.prev_bit;

    // =====================================
    // clear sequencing and lane commands
    always_comb begin
        clr_rise = stats_clear_ctl && !clr_q;
        clr_fall = !stats_clear_ctl && clr_q;
        chk_fall = chk_q & ~chk_en;
        scope = global_start_stop ? {L{1'b1}} : chk_en; // RL7
        next_state = state;
        lif.run = chk_en;
        lif.frz = '0;
        lif.snap_cur = '0;
        lif.snap_prev = '0;
        lif.zap = '0;
        case (state)
            pes_pkg::PES_RUN: begin
                if (clr_rise) begin
                    // copy first, so the ended period survives in previous results, and in current results too while frozen
                    lif.snap_cur = scope; // RL8
                    lif.snap_prev = scope; // RL8
                    if (!lane_gate_timer_cap)
                        next_state = pes_pkg::PES_FREEZE; // RL12
                    else
                        lif.zap = scope; // RL4
                end else if (rt_report_cap && upd_tick) begin
                    lif.snap_cur = chk_en; // RL1
                end
            end
            pes_pkg::PES_FREEZE: begin
                lif.frz = {L{1'b1}}; // RL10
                if (clr_fall) begin
                    // live and current counts are zeroed; host must have read them already
                    lif.zap = scope; // RL11
                    next_state = pes_pkg::PES_RUN;
                end
            end
            default: next_state = pes_pkg::PES_RUN;
        endcase
        // a disabled checker stops and publishes to both sets
        lif.snap_cur = lif.snap_cur | chk_fall; // RL13
        lif.snap_prev = lif.snap_prev | chk_fall; // RL13
        next_clr_q = stats_clear_ctl;
        next_chk_q = chk_en;
        next_frozen = next_state == pes_pkg::PES_FREEZE;
        next_non_gated = gate_time == pes_pkg::GATE_NONE; // RL5
        // auto-restart only means something to a gated window
        next_gate_restart_eff = gate_auto_restart && !next_non_gated; // RL6
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= pes_pkg::PES_RUN;
            clr_q <= 1'b0;
            chk_q <= '0;
            frozen <= 1'b0;
            non_gated <= 1'b1;
            gate_restart_eff <= 1'b0;
        end else begin
            state <= next_state;
            clr_q <= next_clr_q;
            chk_q <= next_chk_q;
            frozen <= next_frozen;
            non_gated <= next_non_gated;
            gate_restart_eff <= next_gate_restart_eff;
        end
    end

    // =====================================
    // checks
    a_rt_refresh_cur: assert property (@(posedge sys_clk) disable iff (rst) // RL1
        rt_report_cap && upd_tick && state == pes_pkg::PES_RUN && !clr_rise |-> (lif.snap_cur & chk_en) == chk_en)
        else $error("real-time refresh missed");
    a_no_rt_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL2
        !rt_report_cap && !clr_rise && chk_fall == '0 |-> lif.snap_cur == '0)
        else $error("results refreshed while counting");
    a_clear_zeroes: assert property (@(posedge sys_clk) disable iff (rst) // RL4
        lane_gate_timer_cap && clr_rise && state == pes_pkg::PES_RUN && scope[0]
        |=> cur_err[0] == '0 && cur_bit[0] == '0)
        else $error("clear did not zero results");
    a_nongated_flag: assert property (@(posedge sys_clk) disable iff (rst) // RL5
        gate_time == pes_pkg::GATE_NONE |=> non_gated)
        else $error("zero gating time not non-gated");
    a_restart_ignored: assert property (@(posedge sys_clk) disable iff (rst) // RL6
        gate_time == pes_pkg::GATE_NONE && gate_auto_restart |=> !gate_restart_eff)
        else $error("auto-restart honoured while non-gated");
    a_global_all_lanes: assert property (@(posedge sys_clk) disable iff (rst) // RL7
        global_start_stop && clr_fall && state == pes_pkg::PES_FREEZE |-> lif.zap == {L{1'b1}})
        else $error("global clear missed lanes");
    a_copy_before_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL8
        clr_rise && state == pes_pkg::PES_RUN |-> (lif.snap_prev & scope) == scope)
        else $error("no copy before clear");
    a_freeze_holds: assert property (@(posedge sys_clk) disable iff (rst) // RL10
        !lane_gate_timer_cap && clr_rise && state == pes_pkg::PES_RUN && scope[0] ##1 stats_clear_ctl [*2]
        |-> frozen && cur_err[0] == prev_err[0])
        else $error("clear held but not frozen");
    a_release_restart: assert property (@(posedge sys_clk) disable iff (rst) // RL11
        state == pes_pkg::PES_FREEZE && clr_fall |-> (lif.zap & chk_en) == chk_en ##1 !frozen)
        else $error("release did not restart");
    a_cap_selects: assert property (@(posedge sys_clk) disable iff (rst) // RL12
        clr_rise && state == pes_pkg::PES_RUN |=> frozen == !$past(lane_gate_timer_cap))
        else $error("freeze mode chosen wrongly");
    a_disable_snap: assert property (@(posedge sys_clk) disable iff (rst) // RL13
        chk_q[0] && !chk_en[0] && !lif.zap[0] |=> cur_err[0] == prev_err[0] && cur_bit[0] == prev_bit[0])
        else $error("disable did not publish counts");
endmodule // pes_stats_ctl

// ==== verification/pes_host_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// host side of the management link: owns the clear bit
module pes_host_model (
    input wire logic sys_clk,
    input wire logic read_done,
    output logic stats_clear_ctl
);
    initial stats_clear_ctl = 1'b0;

    task automatic raise_clear;
        @(negedge sys_clk);
        stats_clear_ctl = 1'b1;
    endtask

    // with lane_gate_timer_cap at 0 release zeroes live and current counts, so wait up to 100 cycles for the reader first
    task automatic release_clear;
        int n;
        n = 0;
        while (!read_done && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        stats_clear_ctl = 1'b0;
    endtask
endmodule // pes_host_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    localparam int N = pes_pkg::NUM_LANES;
    localparam int L = 2 * N;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [N-1:0] host_chk_en = '1;
    logic [N-1:0] media_chk_en = '1;
    logic [L-1:0] hit = '0;
    logic rt_report_cap = 1'b0;
    logic [pes_pkg::UPD_W-1:0] update_period = 8'h00;
    logic stats_clear_ctl;
    logic global_start_stop = 1'b0;
    logic gate_auto_restart = 1'b0;
    logic [pes_pkg::GATE_W-1:0] gate_time = 3'h0;
    logic lane_gate_timer_cap = 1'b0;
    logic read_done = 1'b0;
    logic frozen;
    logic non_gated;
    logic gate_restart_eff;
    logic [pes_pkg::ERR_W-1:0] cur_err [L];
    logic [pes_pkg::ERR_W-1:0] prev_err [L];
    logic [pes_pkg::BIT_W-1:0] cur_bit [L];
    logic [pes_pkg::BIT_W-1:0] prev_bit [L];
    logic [L-1:0] old_en;
    int err_count = 0;
    int check_count = 0;
    int le [L];
    int ce [L];
    int pe [L];
    bit frz_m = 1'b0;

    always #25 sys_clk = ~sys_clk;

    pes_host_model host (.sys_clk(sys_clk), .read_done(read_done), .stats_clear_ctl(stats_clear_ctl));

    pes_stats_ctl #(.UPD_UNIT_CYC(4)) DUT (.sys_clk(sys_clk), .rst(rst), .host_chk_en(host_chk_en),
        .media_chk_en(media_chk_en), .host_err_hit(hit[N-1:0]), .media_err_hit(hit[L-1:N]),
        .rt_report_cap(rt_report_cap), .update_period(update_period), .stats_clear_ctl(stats_clear_ctl),
        .global_start_stop(global_start_stop), .gate_auto_restart(gate_auto_restart), .gate_time(gate_time),
        .lane_gate_timer_cap(lane_gate_timer_cap), .frozen(frozen), .non_gated(non_gated),
        .gate_restart_eff(gate_restart_eff), .cur_err(cur_err), .prev_err(prev_err), .cur_bit(cur_bit),
        .prev_bit(prev_bit));

    // ==========================================================
    // helpers and reference model
    function automatic bit lane_en(input int i);
        return (i < N) ? host_chk_en[i] : media_chk_en[i-N];
    endfunction

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // hits are counted by the model the cycle they are presented
    task automatic cyc(input int n, input bit rnd);
        repeat (n) begin
            @(negedge sys_clk);
            hit = rnd ? L'($urandom) : '0;
            for (int i = 0; i < L; i++) if (hit[i] && lane_en(i) && !frz_m) le[i]++;
        end
    endtask

    task automatic cmp_all;
        for (int i = 0; i < L; i++) begin
            chk("cur_err", 64'(cur_err[i]), 64'(ce[i]));
            chk("prev_err", 64'(prev_err[i]), 64'(pe[i]));
        end
    endtask

    task automatic bits_chk(input bit frz);
        for (int i = 0; i < L; i++) begin
            if (frz) begin
                chk("prev_bit", 64'(prev_bit[i]), 64'(cur_bit[i]));
                chk("bit_step", 64'(cur_bit[i][4:0]), 64'h0);
                chk("bit_live", 64'(cur_bit[i] != '0), 64'h1);
            end else if (global_start_stop || lane_en(i)) begin
                chk("cur_bit", 64'(cur_bit[i]), 64'h0);
            end
        end
    endtask

    // quiet cycles after each clear edge keep the model timing-neutral
    task automatic clear_edge(input bit rise);
        if (rise) host.raise_clear();
        else host.release_clear();
        cyc(3, 0);
        for (int i = 0; i < L; i++) begin
            if (!(global_start_stop || lane_en(i))) continue;
            if (lane_gate_timer_cap) begin
                if (rise) begin
                    pe[i] = le[i];
                    ce[i] = 0;
                    le[i] = 0;
                end
            end else if (rise) begin
                ce[i] = le[i];
                pe[i] = le[i];
            end else begin
                ce[i] = 0;
                le[i] = 0;
            end
        end
        if (!lane_gate_timer_cap) frz_m = rise;
    endtask

    task automatic results;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'h44B5547D));
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        cyc(2, 0);
        cmp_all();
        chk("frozen", 64'(frozen), 64'h0);
        gate_auto_restart = 1'b1;
        cyc(2, 0);
        chk("non_gated", 64'(non_gated), 64'h1);
        chk("gate_restart_eff", 64'(gate_restart_eff), 64'h0);
        gate_time = 3'h1 + 3'($urandom % 7);
        cyc(2, 0);
        chk("non_gated", 64'(non_gated), 64'h0);
        chk("gate_restart_eff", 64'(gate_restart_eff), 64'h1);
        gate_time = 3'h0;
        cyc(2, 0);
        chk("gate_restart_eff", 64'(gate_restart_eff), 64'h0);
        cyc(40, 1);
        cyc(3, 0);
        cmp_all();
        old_en = {media_chk_en, host_chk_en};
        {media_chk_en, host_chk_en} = L'($urandom);
        for (int i = 0; i < L; i++) if (old_en[i] && !lane_en(i)) begin
            ce[i] = le[i];
            pe[i] = le[i];
        end
        cyc(3, 0);
        cmp_all();
        lane_gate_timer_cap = 1'b1;
        read_done = 1'b1;
        cyc(20, 1);
        clear_edge(1);
        cmp_all();
        bits_chk(0);
        clear_edge(0);
        cmp_all();
        global_start_stop = 1'b1;
        cyc(20, 1);
        clear_edge(1);
        cmp_all();
        bits_chk(0);
        clear_edge(0);
        {media_chk_en, host_chk_en} = '1;
        lane_gate_timer_cap = 1'b0;
        read_done = 1'b0;
        cyc(40, 1);
        cyc(3, 0);
        clear_edge(1);
        cmp_all();
        chk("frozen", 64'(frozen), 64'h1);
        bits_chk(1);
        cyc(20, 1);
        cyc(3, 0);
        cmp_all();
        read_done = 1'b1;
        clear_edge(0);
        cmp_all();
        chk("frozen", 64'(frozen), 64'h0);
        bits_chk(0);
        rt_report_cap = 1'b1;
        update_period = 8'h02;
        cyc(40, 1);
        cyc(30, 0);
        for (int i = 0; i < L; i++) ce[i] = le[i];
        cmp_all();
        results();
    end

    initial begin
        repeat (4000) @(posedge sys_clk);
        err_count++;
        results();
    end
endmodule // tb_top
